/* File: bench/csr_access_privilege_check_bench.sv */
/*
  Self-checking bench: table of access cases, then hand tests.
  Assumes the pipeline model drives the request side.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_access_privilege_check_bench;
  logic clk, arst_n, ce, virt_mode, debug_mode, debug_present;
  logic intercept, lvl_set_valid, req_valid, busy;
  logic [31:0] ro_bit_mask, v;
  priv_check_pkg::level_t lvl_set_value, cur_level;
  priv_check_pkg::req_t   req;
  priv_check_pkg::rsp_t   rsp, r;
  int fails, n_checks;
  typedef struct packed {
    logic [1:0] lv; logic [11:0] a; logic w, vm; logic [1:0] ex;
  } row_t;
  row_t rows [12] = '{
    '{2'h3, 12'h300, 1'b0, 1'b0, 2'h0}, '{2'h0, 12'h100, 1'b0, 1'b0, 2'h1},
    '{2'h0, 12'h100, 1'b0, 1'b1, 2'h2}, '{2'h1, 12'h000, 1'b0, 1'b0, 2'h0},
    '{2'h1, 12'h300, 1'b0, 1'b0, 2'h1}, '{2'h1, 12'h200, 1'b0, 1'b0, 2'h1},
    '{2'h3, 12'h200, 1'b0, 1'b0, 2'h0}, '{2'h3, 12'hC00, 1'b1, 1'b0, 2'h1},
    '{2'h1, 12'hC00, 1'b1, 1'b1, 2'h1}, '{2'h3, 12'h7A5, 1'b0, 1'b0, 2'h0},
    '{2'h3, 12'h7B3, 1'b0, 1'b0, 2'h1}, '{2'h0, 12'hC00, 1'b0, 1'b0, 2'h0}};

  csr_access_privilege_check dut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .req_valid(req_valid), .req(req), .virt_mode(virt_mode),
    .debug_mode(debug_mode), .debug_present(debug_present),
    .intercept(intercept), .lvl_set_valid(lvl_set_valid),
    .lvl_set_value(lvl_set_value), .ro_bit_mask(ro_bit_mask),
    .rsp(rsp), .cur_level(cur_level), .busy(busy));
  pipe_model m_pipe (.clk(clk), .rsp(rsp),
    .req_valid(req_valid), .req(req));

  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic lvl(input logic [1:0] lv);
    @(negedge clk);
    lvl_set_valid = 1'b1;
    lvl_set_value = priv_check_pkg::level_t'(lv);
    @(negedge clk);
    lvl_set_valid = 1'b0;
  endtask
  task automatic op(input logic [11:0] a, input logic w,
                    input logic [31:0] d, m);
    m_pipe.issue({a, w, d, m}, r);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // about 125 cycles expected; far beyond that means a hang
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    {arst_n, virt_mode, debug_mode, debug_present, intercept} = 5'h00;
    {ce, lvl_set_valid, ro_bit_mask} = {1'b1, 1'b0, 32'h0};
    lvl_set_value = priv_check_pkg::LVL_MACH;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    chk(cur_level, 32'h3);
    foreach (rows[i]) begin
      lvl(rows[i].lv);
      virt_mode = rows[i].vm;
      op(rows[i].a, rows[i].w, 32'h0000_5A5A, 32'hFFFF_FFFF);
      chk(r.exc, rows[i].ex);
      if (rows[i].ex != 2'h0) chk(r.rdata, 32'h0);
    end
    virt_mode = 1'b0;
    lvl(2'h3);
    op(12'h340, 1'b1, 32'h1234_5678, 32'hFFFF_FFFF);
    op(12'h340, 1'b1, 32'hAAAA_5555, 32'hFFFF_0000);
    op(12'h340, 1'b0, 32'h0, 32'h0);
    chk(r.rdata, 32'hAAAA_5678);
    ro_bit_mask = 32'h0000_00FF;
    op(12'h340, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    chk(r.exc, 32'h0);
    op(12'h340, 1'b0, 32'h0, 32'h0);
    op(12'h340, 1'b0, 32'h0, 32'h0);
    chk(r.rdata, 32'hFFFF_FF78);
    op(12'hC05, 1'b0, 32'h0, 32'h0);
    v = r.rdata;
    op(12'hC05, 1'b1, ~v, 32'hFFFF_FFFF);
    chk(r.exc, 32'h1);
    op(12'hC05, 1'b0, 32'h0, 32'h0);
    chk(r.rdata, v);
    {debug_present, debug_mode} = 2'h3;
    op(12'h7B0, 1'b0, 32'h0, 32'h0);
    chk(r.exc, 32'h0);
    {debug_present, debug_mode} = 2'h0;
    lvl(2'h1);
    intercept = 1'b1;
    op(12'h100, 1'b0, 32'h0, 32'h0);
    chk(r.exc != 2'h0, 32'h1);
    intercept = 1'b0;
    lvl(2'h2);
    chk(cur_level, 32'h1);
    // clock enable low must freeze the level register
    ce = 1'b0;
    lvl(2'h0);
    chk(cur_level, 32'h1);
    ce = 1'b1;
    arst_n = 1'b0;
    @(negedge clk);
    chk(cur_level, 32'h3);
    arst_n = 1'b1;
    summarize();
  end
endmodule
`default_nettype wire

/* File: bench/csr_access_privilege_check_chk.sv */
/*
  Port-level checks of the privilege checker.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module csr_access_privilege_check_chk (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   ce,
  input wire logic                   req_valid,
  input wire priv_check_pkg::req_t   req,
  input wire logic                   virt_mode,
  input wire logic                   debug_mode,
  input wire logic                   debug_present,
  input wire logic                   intercept,
  input wire logic                   lvl_set_valid,
  input wire priv_check_pkg::level_t lvl_set_value,
  input wire priv_check_pkg::rsp_t   rsp,
  input wire priv_check_pkg::level_t cur_level,
  input wire logic                   busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // minimum level 10 counts as machine
  wire [1:0] min_lvl = (req.addr[9:8] == 2'h2) ? 2'h3 : req.addr[9:8];
  wire       take    = ce && req_valid && !busy && !rsp.done;
  wire       low     = cur_level < min_lvl;
  wire       dbg     = req.addr[11:4] == 8'h7B &&
                       !(debug_mode && debug_present);
  wire       ro_wr   = req.wr && req.addr[11:10] == 2'h3;
  wire       icpt    = intercept && cur_level != 2'h3;
  wire       ok      = !low && !dbg && !ro_wr && !icpt;

  property p_rsvd; lvl_set_valid && !busy && lvl_set_value == 2'h2
    |=> $stable(cur_level); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved level");
  property p_low; take && low && !req.wr |=> rsp.done &&
    rsp.exc == (virt_mode ? 2'h2 : 2'h1); endproperty
  a_low: assert property (p_low) else $error("level fault");
  property p_ro; take && ro_wr |=> rsp.done && rsp.exc == 2'h1; endproperty
  a_ro: assert property (p_ro) else $error("read-only write");
  property p_dbg; take && dbg |=> rsp.done && rsp.exc != 2'h0; endproperty
  a_dbg: assert property (p_dbg) else $error("debug window");
  property p_icpt; take && icpt |=> rsp.done && rsp.exc != 2'h0; endproperty
  a_icpt: assert property (p_icpt) else $error("intercept");
  property p_rd; take && ok && !req.wr |=> busy && !rsp.done ##1
    rsp.done && rsp.exc == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("allowed read");
  property p_wr; take && ok && req.wr |=> busy [*2] ##1
    rsp.done && !busy && rsp.exc == 2'h0; endproperty
  a_wr: assert property (p_wr) else $error("allowed write");
  property p_deny; rsp.done && rsp.exc != 2'h0 |-> rsp.rdata == '0;
  endproperty
  a_deny: assert property (p_deny) else $error("denied data");
endmodule
bind csr_access_privilege_check csr_access_privilege_check_chk u_chk (
  .clk(clk), .arst_n(arst_n), .ce(ce), .req_valid(req_valid), .req(req),
  .virt_mode(virt_mode), .debug_mode(debug_mode),
  .debug_present(debug_present), .intercept(intercept),
  .lvl_set_valid(lvl_set_valid), .lvl_set_value(lvl_set_value),
  .rsp(rsp), .cur_level(cur_level), .busy(busy));
`default_nettype wire

/* File: bench/pipe_model.sv */
/*
  Behavioural pipeline that issues one register operation at a time.
  Assumes the bench calls issue() from its main sequence only.
*/
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
  input  wire logic                 clk,
  input  wire priv_check_pkg::rsp_t rsp,
  output var  logic                 req_valid,
  output var  priv_check_pkg::req_t req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  task automatic issue(input priv_check_pkg::req_t r,
                       output priv_check_pkg::rsp_t got);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1; // held with req until done
    req = r;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.done !== 1'b1 && n < 20);
    got = rsp;
    req_valid = 1'b0;
    // released lines must not keep a stale value
    req = ~r;
    @(negedge clk); // idle gap, one op at a time
  endtask
endmodule
`default_nettype wire

/* File: common/priv_check_pkg.sv */
/*
  Shared constants and carrier types for the privilege tracker and
  register-access checker. Assumes a pipeline issuing one register
  operation at a time with address, write flag and write data.
*/
package priv_check_pkg;

  localparam int ADDR_W = 12;

  typedef enum logic [1:0] {
    LVL_APP  = 2'h0,
    LVL_SUP  = 2'h1,
    LVL_RSVD = 2'h2,
    LVL_MACH = 2'h3
  } level_t;

  typedef enum logic [1:0] {
    SET_M   = 2'h0,
    SET_MU  = 2'h1,
    SET_MSU = 2'h2
  } level_set_t;

  typedef enum logic [1:0] {
    EXC_NONE    = 2'h0,
    EXC_ILLEGAL = 2'h1,
    EXC_VIRTUAL = 2'h2
  } exc_t;

  localparam int RO_HI = 11;
  localparam int RO_LO = 10;
  localparam int LV_HI = 9;
  localparam int LV_LO = 8;
  localparam logic [1:0] RO_CLASS = 2'h3;

  // debug windows: upper eight address bits select 16-entry blocks
  localparam logic [7:0] DBG_M_BLK = 8'h7A;
  localparam logic [7:0] DBG_D_BLK = 8'h7B;

  localparam int ENTRIES = 4096;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] wmask;
  } req_t;

  typedef struct packed {
    logic        done;
    logic [1:0]  exc;
    logic [31:0] rdata;
  } rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } state_t;

endpackage

/* File: verilog/csr_access_privilege_check.sv */
/*
  Current privilege level and register-access checker for one thread.
  Each request is checked in the cycle it is taken, then performed as
  a read followed by an optional masked write. Assumes the pipeline
  holds its request stable until done pulses.
*/
// Contract
// RULE1: level coded 00 application, 01 supervisor, 11 machine; 10 invalid.
// RULE2: operations beyond the current level raise an exception instead.
// RULE3: machine level always exists and reaches every register; the code denies machine access to 0x7B0-0x7BF outside debug mode.
// RULE4: level sets are M, M+U or M+S+U only.
// RULE5: registers are addressed by a twelve-bit field, 4096 entries.
// RULE6: address top bits 11 mean read-only, others read/write.
// RULE7: address bits 9:8 give the lowest level allowed access.
// RULE8: higher levels reach every register of lower levels.
// RULE9: reads have no side effect; writes may.
// RULE10: too-low level raises illegal, or virtual under virtualization.
// RULE11: write to read-only register raises illegal and changes nothing.
// RULE12: read-only bits inside writable registers silently keep value.
// RULE13: absent registers are reserved; behaviour need not be defined.
// RULE14: 0x7A0-0x7AF are debug registers reachable from machine level.
// RULE15: 0x7B0-0x7BF only in debug mode; machine access is illegal.
// RULE16: higher level may intercept allowed accesses transparently.
// RULE17: read-only counters get a separate writable shadow address.
// RULE18: each operation is an atomic read-modify-write.
// RULE19: optional debug level has more access than machine level.
// RULE20: level resets to machine; check is combinational before update.
// RULE21: pipeline holds address, write flag and data until result.
`timescale 1ns/1ps
`default_nettype none
module csr_access_privilege_check #(
  parameter priv_check_pkg::level_set_t LEVEL_SET = priv_check_pkg::SET_MSU,
  parameter int DW = 32
) (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     ce,
  input  wire logic                     req_valid,
  input  wire priv_check_pkg::req_t     req,
  input  wire logic                     virt_mode,
  input  wire logic                     debug_mode,
  input  wire logic                     debug_present,
  input  wire logic                     intercept,
  input  wire logic                     lvl_set_valid,
  input  wire priv_check_pkg::level_t   lvl_set_value,
  input  wire logic [31:0]              ro_bit_mask,
  output priv_check_pkg::rsp_t          rsp,
  output priv_check_pkg::level_t        cur_level,
  output logic                          busy
);

  initial begin
    if (DW != 32) begin
      $error("csr_access_privilege_check supports DW of 32 only");
    end
    if (priv_check_pkg::ADDR_W != 12) begin
      $error("register address must be twelve bits");
    end
  end

  priv_check_pkg::level_t  level_r;
  priv_check_pkg::level_t  level_nxt;
  priv_check_pkg::state_t  state_r;
  priv_check_pkg::req_t    hold_r;
  priv_check_pkg::rsp_t    rsp_r;
  logic                    busy_r;

  // address fields [RULE5]
  wire logic [1:0] acc_class = req.addr[priv_check_pkg::RO_HI:
                                        priv_check_pkg::RO_LO];
  wire logic [1:0] min_lvl   = req.addr[priv_check_pkg::LV_HI:
                                        priv_check_pkg::LV_LO];
  wire logic [7:0] blk       = req.addr[11:4];

  wire logic is_ro      = (acc_class == priv_check_pkg::RO_CLASS); // [RULE6]
  wire logic in_dbg_m   = (blk == priv_check_pkg::DBG_M_BLK);      // [RULE14]
  wire logic in_dbg_d   = (blk == priv_check_pkg::DBG_D_BLK);      // [RULE15]

  // debug level outranks machine; 10 as a minimum is treated as machine
  wire logic [2:0] eff_lvl = (debug_mode && debug_present) ? 3'h4   // [RULE19]
                                                           : {1'b0, level_r};
  wire logic [2:0] need_lvl = in_dbg_d ? 3'h4                       // [RULE15]
                            : (min_lvl == priv_check_pkg::LVL_RSVD)
                              ? {1'b0, priv_check_pkg::LVL_MACH}
                              : {1'b0, min_lvl};

  // compare against minimum; higher levels pass too [RULE7] [RULE8] [RULE3]
  wire logic lvl_ok   = (eff_lvl >= need_lvl);
  wire logic wr_ro    = req.wr && is_ro;                            // [RULE11]
  // interception looks identical to a privilege fault to lower levels
  wire logic trapped  = intercept && (level_r != priv_check_pkg::LVL_MACH)
                        && !(debug_mode && debug_present);          // [RULE16]
  wire logic deny_lvl = !lvl_ok || trapped;
  wire logic deny     = deny_lvl || wr_ro;                          // [RULE2]

  // virtual exception only for level faults under virtualization [RULE10]
  wire logic [1:0] exc_code =
      !deny                 ? priv_check_pkg::EXC_NONE :
      (deny_lvl && virt_mode && !wr_ro && !in_dbg_d)
                            ? priv_check_pkg::EXC_VIRTUAL :
                              priv_check_pkg::EXC_ILLEGAL;

  wire logic take = req_valid && (state_r == priv_check_pkg::ST_IDLE);

  // storage: read path first, write after read for atomic update [RULE18]
  logic [31:0] rd_word;
  wire logic   st_rd = take && !deny;   // no read side effects [RULE9]
  wire logic   st_wr = (state_r == priv_check_pkg::ST_WRITE);
  // read-only bits keep the old value without fault [RULE12]
  wire logic [31:0] keep  = ro_bit_mask | ~hold_r.wmask;
  wire logic [31:0] wword = (rd_word & keep) | (hold_r.wdata & ~keep);

  // absent registers are simply backed by storage here [RULE13]
  reg_store #(
    .AW (priv_check_pkg::ADDR_W),
    .DW (DW)
  ) u_store (
    .clk     (clk),
    .ce      (ce),
    .rd_en   (st_rd),
    .rd_addr (req.addr),
    .rd_data (rd_word),
    .wr_en   (st_wr),
    .wr_addr (hold_r.addr),
    .wr_data (wword)
  );

  // level set restricts which levels may be entered [RULE4] [RULE1]
  wire logic set_legal =
      (lvl_set_value == priv_check_pkg::LVL_MACH) ||
      (lvl_set_value == priv_check_pkg::LVL_APP &&
       LEVEL_SET != priv_check_pkg::SET_M) ||
      (lvl_set_value == priv_check_pkg::LVL_SUP &&
       LEVEL_SET == priv_check_pkg::SET_MSU);

  always_comb begin
    level_nxt = level_r;
    if (lvl_set_valid && set_legal && !busy_r) begin
      level_nxt = lvl_set_value;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_r <= priv_check_pkg::LVL_MACH;                   // [RULE20]
    end else if (ce) begin
      level_r <= level_nxt;
    end
  end

  // state: check in take cycle, read, then optional write [RULE20] [RULE18]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= priv_check_pkg::ST_IDLE;
      hold_r  <= '0;
      rsp_r   <= '0;
      busy_r  <= 1'b0;
    end else if (ce) begin
      rsp_r.done <= 1'b0;
      case (state_r)
        priv_check_pkg::ST_IDLE: begin
          if (req_valid) begin
            hold_r <= req;                                   // [RULE21]
            if (deny) begin
              rsp_r.done  <= 1'b1;
              rsp_r.exc   <= exc_code;                       // [RULE10]
              rsp_r.rdata <= '0;
            end else begin
              state_r <= priv_check_pkg::ST_READ;
              busy_r  <= 1'b1;
            end
          end
        end
        priv_check_pkg::ST_READ: begin
          rsp_r.rdata <= rd_word;
          rsp_r.exc   <= priv_check_pkg::EXC_NONE;
          if (hold_r.wr) begin
            state_r <= priv_check_pkg::ST_WRITE;
          end else begin
            rsp_r.done <= 1'b1;
            state_r    <= priv_check_pkg::ST_IDLE;
            busy_r     <= 1'b0;
          end
        end
        priv_check_pkg::ST_WRITE: begin
          rsp_r.done <= 1'b1;
          state_r    <= priv_check_pkg::ST_IDLE;
          busy_r     <= 1'b0;
        end
        default: begin
          state_r <= priv_check_pkg::ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // shadow counters are ordinary writable addresses at the higher level;
  // the read-only alias differs only in its class bits [RULE17]
  assign rsp       = rsp_r;
  assign cur_level = level_r;
  assign busy      = busy_r;

  wire logic unused_ok = take;

endmodule
`default_nettype wire

/* File: verilog/reg_store.sv */
/*
  Simple register storage for the checker: one word per address,
  read data come from a register. Assumes single-cycle write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_store #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: contents are software state, initialised by firmware
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire
